//--- logic/imbr_core.sv
// Two-wire master with dummy-clock bus recovery and plain register port.
//
// Summary of operation
// - Recovery sends at most eight dummy clocks
// - Dummy clocks only in clocked synchronous format
// - Late receive-disable still halts after the current byte
// - Stop at ninth fall adds one pulse when receiving
// - Disable or soft reset clears busy, stop
// - Stop with ack check still driven
// - Recovery clocks stop once data seen high
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module imbr_core
   import imbr_pkg::*;
(
   input wire logic clk_sys_in, // System clock, 10 MHz
   input wire logic rst_n_in, // Synchronous reset, active low
   input wire logic [2:0] addr_in, // Register index
   input wire logic [7:0] wdata_in, // Write data
   input wire logic wr_in, // Write strobe
   input wire logic rd_in, // Read strobe
   output logic [7:0] rdata_out, // Read data, cycle after strobe
   output logic irq_out, // Level interrupt
   input wire logic scl_in, // Clock line level
   output logic scl_out, // Clock drive value, always low
   output logic scl_oe_out, // Clock line pulled low when high
   input wire logic sda_in, // Data line level
   output logic sda_out, // Data drive value, always low
   output logic sda_oe_out // Data line pulled low when high
);
   imbr_state_e state;
   logic [7:0] ctrl, txd, rx_data_reg, shift, ist, imask;
   logic [3:0] bit_cnt, rec_cnt;
   logic scl_s1, scl_s2, scl_s3, clock_line_monitor;
   logic sda_s1, sda_s2, sda_s3, sda_f;
   logic tick, stop_pend;
   logic rx_full_flag, transmit_end_flag, stop_det, bus_busy_flag;
   logic nack_flag, rec_fail_flag;
   logic ev_rxf, ev_transmit_end_flag, ev_nack, ev_stop, ev_start, ev_recok, ev_recfail;
   logic wr_ctrl, wr_cmd, wr_txd, rd_rxd, soft_clr;
   logic cmd_start, cmd_stop, cmd_go, tx_mode, rec_cond;

   assign wr_ctrl = wr_in && addr_in == A_CTRL;
   assign wr_cmd = wr_in && addr_in == A_CMD;
   assign wr_txd = wr_in && addr_in == A_TXD;
   assign rd_rxd = rd_in && addr_in == A_RXD;
   assign soft_clr = !ctrl[C_ENA] || (wr_ctrl && wdata_in[C_SRST]);
   assign cmd_start = wr_cmd && wdata_in[K_START];
   assign cmd_stop = wr_cmd && wdata_in[K_STOP];
   assign cmd_go = wr_cmd && wdata_in[K_GO];
   assign tx_mode = ctrl[C_TRS];
   assign rec_cond = ctrl[C_SYNC] && ctrl[C_MST] && !ctrl[C_TRS];

   // Pull-down value for the bit at idx; ack slot drives from ack value when receiving, released when sending
   function automatic logic bit_drive(input logic [3:0] idx,
                                      input logic tx,
                                      input logic b7,
                                      input logic ackv);
      if (idx == ACK_IDX)
         bit_drive = tx ? 1'b0 : !ackv;
      else
         bit_drive = tx ? !b7 : 1'b0;
   endfunction : bit_drive

   imbr_tick_div u_div (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .run_in(state != S_IDLE),
      .tick_out(tick)
   );

   // Pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         {scl_s1, scl_s2, scl_s3, clock_line_monitor} <= 4'hf;
         {sda_s1, sda_s2, sda_s3, sda_f} <= 4'hf;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         if (scl_s2 == scl_s3)
            clock_line_monitor <= scl_s3;
         if (sda_s2 == sda_s3)
            sda_f <= sda_s3;
      end
   end

   // Control register; soft-reset bit is a strobe and is not stored
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl <= RST_BYTE;
         txd <= RST_BYTE;
         imask <= RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wdata_in;
            ctrl[C_SRST] <= 1'b0;
         end else if (ev_recok || ev_recfail) begin
            ctrl[C_SYNC] <= 1'b0;
         end
         if (wr_txd)
            txd <= wdata_in;
         if (wr_in && addr_in == A_IMASK)
            imask <= wdata_in & IST_USED;
      end
   end

   // Serial engine; every state but S_IDLE lasts one half-bit tick
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || soft_clr) begin
         state <= S_IDLE;
         scl_oe_out <= 1'b0;
         sda_oe_out <= 1'b0;
         bit_cnt <= CNT_ZERO;
         rec_cnt <= CNT_ZERO;
         shift <= RST_BYTE;
         rx_data_reg <= RST_BYTE;
         stop_pend <= 1'b0;
         {ev_rxf, ev_transmit_end_flag, ev_nack, ev_stop} <= 4'h0;
         {ev_start, ev_recok, ev_recfail} <= 3'h0;
      end else begin
         {ev_rxf, ev_transmit_end_flag, ev_nack, ev_stop} <= 4'h0;
         {ev_start, ev_recok, ev_recfail} <= 3'h0;
         if (cmd_stop)
            stop_pend <= 1'b1;
         unique case (state)
            S_IDLE: begin
               if ((stop_pend || cmd_stop) && bus_busy_flag) begin
                  // Ack check on or off, the stop is always driven
                  state <= S_STOP_A;
                  scl_oe_out <= 1'b1;
                  sda_oe_out <= 1'b1;
               end else if (rec_cond) begin
                  // Clocks start as soon as sync master receive is set
                  state <= S_REC_LO;
                  scl_oe_out <= 1'b1;
                  sda_oe_out <= 1'b0;
                  rec_cnt <= CNT_ZERO;
               end else if (cmd_start && !bus_busy_flag && ctrl[C_MST]) begin
                  state <= S_START_A;
                  scl_oe_out <= 1'b0;
                  sda_oe_out <= 1'b1;
               end else if (bus_busy_flag && wr_txd && tx_mode) begin
                  state <= S_LO;
                  bit_cnt <= CNT_ZERO;
                  shift <= wdata_in;
                  sda_oe_out <= bit_drive(CNT_ZERO, 1'b1, wdata_in[7],
                                          1'b0);
               end else if (bus_busy_flag && cmd_go && !tx_mode) begin
                  state <= S_LO;
                  bit_cnt <= CNT_ZERO;
                  sda_oe_out <= 1'b0;
               end
            end
            S_START_A: if (tick) begin
               state <= S_START_B;
               scl_oe_out <= 1'b1;
               ev_start <= 1'b1;
            end
            S_START_B: if (tick) state <= S_IDLE;
            S_LO: if (tick) begin
               state <= S_HI;
               scl_oe_out <= 1'b0;
            end
            S_HI: if (tick) begin
               scl_oe_out <= 1'b1;
               if (bit_cnt == ACK_IDX) begin
                  sda_oe_out <= 1'b0;
                  if (tx_mode) begin
                     ev_transmit_end_flag <= 1'b1;
                     ev_nack <= sda_f;
                     state <= S_IDLE;
                  end else begin
                     ev_rxf <= 1'b1;
                     rx_data_reg <= shift;
                     if (cmd_stop)
                        state <= S_EXTRA_LO;
                     else if (!ctrl[C_RECEIVE_DISABLE] && !stop_pend) begin
                        state <= S_LO;
                        bit_cnt <= CNT_ZERO;
                     end else
                        state <= S_IDLE;
                  end
               end else begin
                  state <= S_LO;
                  bit_cnt <= bit_cnt + CNT_ONE;
                  shift <= {shift[6:0], sda_f};
                  sda_oe_out <= bit_drive(bit_cnt + CNT_ONE, tx_mode,
                                          shift[6], ctrl[C_ACKBIT]);
               end
            end
            // One surplus pulse when stop meets the ninth fall while receiving
            S_EXTRA_LO: if (tick) begin
               state <= S_EXTRA_HI;
               scl_oe_out <= 1'b0;
            end
            S_EXTRA_HI: if (tick) begin
               state <= S_IDLE;
               scl_oe_out <= 1'b1;
            end
            S_STOP_A: if (tick) begin
               state <= S_STOP_B;
               scl_oe_out <= 1'b0;
               stop_pend <= 1'b0;
            end
            S_STOP_B: if (tick) begin
               state <= S_STOP_C;
               sda_oe_out <= 1'b0;
               ev_stop <= 1'b1;
            end
            S_STOP_C: if (tick) state <= S_IDLE;
            S_REC_LO: if (tick) begin
               state <= S_REC_HI;
               scl_oe_out <= 1'b0;
               rec_cnt <= rec_cnt + CNT_ONE;
            end
            S_REC_HI: if (tick) begin
               scl_oe_out <= 1'b1;
               if (sda_f || rec_cnt == DUMMY_CLOCKS) begin
                  // Back to two-wire format, finish with a stop
                  state <= S_STOP_A;
                  sda_oe_out <= 1'b1;
                  ev_recok <= sda_f;
                  ev_recfail <= !sda_f;
               end else
                  state <= S_REC_LO;
            end
         endcase
      end
   end

   // Status flags; hardware set wins over a same-cycle clear
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         {rx_full_flag, transmit_end_flag, nack_flag} <= 3'h0;
         {stop_det, bus_busy_flag, rec_fail_flag} <= 3'h0;
      end else if (soft_clr) begin
         // Defined instead of undefined: busy and stop both drop
         bus_busy_flag <= 1'b0;
         stop_det <= 1'b0;
         rx_full_flag <= 1'b0;
         transmit_end_flag <= 1'b0;
         nack_flag <= 1'b0;
      end else begin
         rx_full_flag <= ev_rxf || (rx_full_flag && !rd_rxd);
         transmit_end_flag <= ev_transmit_end_flag || (transmit_end_flag && !wr_txd);
         nack_flag <= (ev_transmit_end_flag && ev_nack) || (nack_flag && !wr_txd);
         stop_det <= ev_stop || (stop_det && !cmd_start);
         bus_busy_flag <= ev_start || (bus_busy_flag && !ev_stop);
         rec_fail_flag <= ev_recfail || (rec_fail_flag && !ev_recok);
      end
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ist <= RST_BYTE;
         irq_out <= 1'b0;
      end else begin
         ist[I_TRANSMIT_END_FLAG] <= ev_transmit_end_flag;
         ist[I_RXF] <= ev_rxf;
         ist[I_STOP] <= ev_stop;
         ist[I_NACK] <= ev_transmit_end_flag && ev_nack;
         ist[I_RECOK] <= ev_recok;
         ist[I_RECFAIL] <= ev_recfail;
         for (int i = I_TRANSMIT_END_FLAG; i <= I_RECFAIL; i++) begin
            if (ist[i] && !(wr_in && addr_in == A_IST && wdata_in[i]))
               ist[i] <= 1'b1;
         end
         irq_out <= |(ist & imask);
      end
   end

   // Read port; data stand one cycle only
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || !rd_in) begin
         rdata_out <= RST_BYTE;
      end else begin
         unique case (addr_in)
            A_CTRL: rdata_out <= ctrl;
            A_TXD: rdata_out <= txd;
            A_RXD: rdata_out <= rx_data_reg;
            A_STAT: rdata_out <= {rec_fail_flag, nack_flag, sda_f,
                                  clock_line_monitor, bus_busy_flag,
                                  stop_det, transmit_end_flag,
                                  rx_full_flag};
            A_IST: rdata_out <= ist;
            A_IMASK: rdata_out <= imask;
            default: rdata_out <= RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   property p_rec_cap;
      (state == S_REC_LO || state == S_REC_HI) |-> rec_cnt <= DUMMY_CLOCKS;
   endproperty
   a_rec_cap: assert property (p_rec_cap)
      else $error("more than eight dummy clocks");
   property p_fail_eight;
      ev_recfail |-> $past(rec_cnt) == DUMMY_CLOCKS;
   endproperty
   a_fail_eight: assert property (p_fail_eight)
      else $error("recovery failed before eight clocks");
   property p_rec_entry;
      $rose(state == S_REC_LO) |-> $past(rec_cond) && $past(ctrl[C_ENA]);
   endproperty
   a_rec_entry: assert property (p_rec_entry)
      else $error("dummy clocks outside sync receive format");
   property p_rec_halt;
      state == S_REC_HI && tick && sda_f && !soft_clr
         |=> state == S_STOP_A && ev_recok;
   endproperty
   a_rec_halt: assert property (p_rec_halt)
      else $error("recovery clocks continued with data high");
   property p_after_rec;
      // Format bit drops on the edge that sees the result pulse
      (ev_recok || ev_recfail) && !wr_ctrl |=> !ctrl[C_SYNC]
         && state == S_STOP_A;
   endproperty
   a_after_rec: assert property (p_after_rec)
      else $error("no return to two-wire format with stop");
   property p_extra;
      state == S_HI && tick && bit_cnt == ACK_IDX && !tx_mode && cmd_stop
         && !soft_clr |=> state == S_EXTRA_LO ##1 scl_oe_out;
   endproperty
   a_extra: assert property (p_extra)
      else $error("missing surplus clock pulse");
   property p_srst;
      wr_ctrl && wdata_in[C_SRST] |=> !bus_busy_flag && !stop_det
         && state == S_IDLE;
   endproperty
   a_srst: assert property (p_srst)
      else $error("busy or stop flag kept over soft reset");
   property p_stop_go;
      state == S_IDLE && bus_busy_flag && stop_pend && !soft_clr
         |=> state == S_STOP_A && sda_oe_out && scl_oe_out;
   endproperty
   a_stop_go: assert property (p_stop_go)
      else $error("pending stop not started");
   c_rec_ok: cover property (ev_recok);
   c_rec_fail: cover property (ev_recfail);
   c_extra: cover property (state == S_EXTRA_HI);
   c_rx_byte: cover property (ev_rxf && !ctrl[C_RECEIVE_DISABLE]);
endmodule : imbr_core

//--- logic/imbr_pkg.sv
// Shared constants and types of the bus-recovery two-wire master.
package imbr_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int HALF_CYC = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [5:0] HALF_CNT_MAX = 6'(HALF_CYC - 1);
   localparam logic [5:0] HALF_CNT_ZERO = 6'h00;
   // Byte framing
   localparam logic [3:0] ACK_IDX = 4'h8;
   localparam logic [3:0] DUMMY_CLOCKS = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // Register indices on the plain port
   localparam logic [2:0] A_CTRL = 3'h0;
   localparam logic [2:0] A_CMD = 3'h1;
   localparam logic [2:0] A_TXD = 3'h2;
   localparam logic [2:0] A_RXD = 3'h3;
   localparam logic [2:0] A_STAT = 3'h4;
   localparam logic [2:0] A_IST = 3'h5;
   localparam logic [2:0] A_IMASK = 3'h6;
   // Control bits (bus_control_reg_one / bus_control_reg_two merged)
   localparam int C_ENA = 0;
   localparam int C_SRST = 1;
   localparam int C_SYNC = 2;
   localparam int C_MST = 3;
   localparam int C_TRS = 4;
   localparam int C_RECEIVE_DISABLE = 5;
   localparam int C_ACKBIT = 6;
   localparam int C_ACK_CHECK_ENABLE = 7;
   // Command bits
   localparam int K_START = 0;
   localparam int K_STOP = 1;
   localparam int K_GO = 2;
   // Interrupt status bits
   localparam int I_TRANSMIT_END_FLAG = 0;
   localparam int I_RXF = 1;
   localparam int I_STOP = 2;
   localparam int I_NACK = 3;
   localparam int I_RECOK = 4;
   localparam int I_RECFAIL = 5;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] IST_USED = 8'h3f;
   typedef enum logic [3:0] {
      S_IDLE, S_START_A, S_START_B, S_LO, S_HI, S_EXTRA_LO, S_EXTRA_HI,
      S_STOP_A, S_STOP_B, S_STOP_C, S_REC_LO, S_REC_HI
   } imbr_state_e;
endpackage : imbr_pkg

//--- logic/imbr_tick_div.sv
// Half-bit tick divider for the serial clock phases.
`timescale 1ns/1ps
module imbr_tick_div
   import imbr_pkg::*;
(
   input wire logic clk_sys_in, // System clock
   input wire logic rst_n_in, // Synchronous reset, active low
   input wire logic run_in, // Count while high, restart when low
   output logic tick_out // One-cycle pulse each half bit
);
   logic [5:0] cnt;

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || !run_in) begin
         cnt <= HALF_CNT_ZERO;
         tick_out <= 1'b0;
      end else if (cnt == HALF_CNT_MAX) begin
         cnt <= HALF_CNT_ZERO;
         tick_out <= 1'b1;
      end else begin
         cnt <= cnt + 6'h01;
         tick_out <= 1'b0;
      end
   end
endmodule : imbr_tick_div

//--- testbench/imbr_core_tb.sv
// Self-checking bench of the bus-recovery two-wire master.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   errors++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module imbr_core_tb
   import imbr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic irq, scl_oe, sda_oe, slv_oe, scl, sda, scl_o, sda_o;
   logic hold = 1'b0;
   logic [3:0] hold_falls = 4'h0;
   logic [7:0] d;
   int errors = 0;
   int n_checks = 0;
   int n_rise = 0;
   int n_stop = 0;
   logic [2:0] ra [7] = '{A_CTRL, A_CMD, A_RXD, A_STAT, A_IST, A_IMASK, 3'h7};
   logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
   logic [3:0] kf [3] = '{4'h3, 4'h8, 4'h0};
   int ke [3] = '{4, 9, 9};
   int ks [3] = '{1, 1, 0};
   logic [1:0] ki [3] = '{2'b01, 2'b01, 2'b10};
   logic [7:0] sr [2] = '{8'h1b, 8'h00};
   // Open-drain wires with pull-ups
   assign scl = ~scl_oe;
   assign sda = ~(sda_oe | slv_oe);
   always #50 clk_sys = ~clk_sys;
   always @(posedge scl) n_rise++;
   always @(posedge sda) if (scl === 1'b1) n_stop++;
   imbr_core imbr_core_inst (.clk_sys_in(clk_sys), .rst_n_in(rst_n),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .irq_out(irq), .scl_in(scl), .scl_out(scl_o),
      .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_o),
      .sda_oe_out(sda_oe));
   imbr_eeprom_model imbr_eeprom_model_inst (.scl_in(scl), .sda_in(sda),
      .hold_in(hold), .hold_falls_in(hold_falls), .rd_byte_in(8'h5a),
      .sda_oe_out(slv_oe));
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   // Bounded poll, long enough for two byte times
   task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
      for (int i = 0; i < 3000; i++) begin
         rd_reg(a, d);
         if (d[b] === v) break;
      end
      `CHK("wait", v, d[b])
   endtask : wait_bit
   task automatic start_bus(input logic [7:0] c);
      wr_reg(A_CTRL, c);
      wr_reg(A_CMD, 8'h01);
      wait_bit(A_STAT, 3, 1'b1);
      // Busy rises a half bit before the engine is idle again
      repeat (HALF_CYC + 2) @(posedge clk_sys);
   endtask : start_bus
   task automatic send_byte(input logic [7:0] c, input logic [7:0] v);
      start_bus(c);
      wr_reg(A_TXD, v);
      wait_bit(A_STAT, 1, 1'b1);
      `CHK("slave ack", 1'b0, d[6])
   endtask : send_byte
   task automatic stop_bus(input string nm);
      n_stop = 0;
      wr_reg(A_CMD, 8'h02);
      wait_bit(A_STAT, 2, 1'b1);
      // Let the closing half bit of the stop run out
      repeat (HALF_CYC + 2) @(posedge clk_sys);
      `CHK(nm, 1, n_stop)
   endtask : stop_bus
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      $display("[FAIL] watchdog exp done got hang");
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd_reg(ra[i], d);
         `CHK("reset value", rv[i], d)
      end
      wr_reg(3'h7, 8'hff);
      rd_reg(3'h7, d);
      `CHK("unmapped", 8'h00, d)
      `CHK("drive values", 2'b00, {scl_o, sda_o})
      wr_reg(A_IMASK, 8'hff);
      rd_reg(A_IMASK, d);
      `CHK("mask width", 8'h3f, d)
      wr_reg(A_IMASK, 8'h10);
      wr_reg(A_CTRL, 8'h01);
      // Early release, release at the last clock, never released
      for (int i = 0; i < 3; i++) begin
         hold_falls <= kf[i];
         hold <= 1'b1;
         n_rise = 0;
         n_stop = 0;
         wr_reg(A_CTRL, 8'h0d);
         wait_bit(A_IST, (i == 2) ? 5 : 4, 1'b1);
         repeat (200) @(posedge clk_sys);
         `CHK("dummy clocks", ke[i], n_rise)
         `CHK("recovery stop", ks[i], n_stop)
         rd_reg(A_IST, d);
         `CHK("recovery result", ki[i], d[5:4])
         rd_reg(A_CTRL, d);
         `CHK("format back", 1'b0, d[C_SYNC])
         `CHK("irq level", i < 2, irq)
         wr_reg(A_IST, 8'h3f);
         hold <= 1'b0;
         repeat (2) @(posedge clk_sys);
         #1 `CHK("irq clear", 1'b0, irq)
      end
      send_byte(8'h19, 8'ha1);
      wr_reg(A_CTRL, 8'h69);
      wr_reg(A_CMD, 8'h04);
      n_rise = 0;
      wait_bit(A_STAT, 0, 1'b1);
      wait_bit(A_STAT, 4, 1'b0);
      rd_reg(A_RXD, d);
      `CHK("rx byte", 8'h5a, d)
      rd_reg(A_STAT, d);
      `CHK("rx full clear", 1'b0, d[0])
      stop_bus("stop after byte");
      // Nine byte clocks and the stop release, nothing more
      `CHK("no extra pulse", 10, n_rise)
      send_byte(8'h99, 8'ha0);
      stop_bus("stop with ack check");
      // Stop lands on the edge of the ninth fall: one surplus pulse
      send_byte(8'h19, 8'ha1);
      wr_reg(A_CTRL, 8'h69);
      wr_reg(A_CMD, 8'h04);
      n_rise = 0;
      repeat (18 * HALF_CYC - 1) @(posedge clk_sys);
      stop_bus("stop at ninth fall");
      // Nine byte clocks, the surplus one and the stop release
      `CHK("extra pulse", 11, n_rise)
      // Soft reset, then disable, each with the bus busy after a start and no byte moving
      for (int i = 0; i < 2; i++) begin
         start_bus(8'h19);
         wr_reg(A_CTRL, sr[i]);
         rd_reg(A_STAT, d);
         `CHK("busy and stop", 2'b00, d[3:2])
      end
      end_sim();
   end
endmodule : imbr_core_tb

//--- testbench/imbr_eeprom_model.sv
// Behavioural serial memory on the two-wire bus, with a stuck-data fault.
`timescale 1ns/1ps
module imbr_eeprom_model (
   input wire logic scl_in, // Clock wire level
   input wire logic sda_in, // Data wire level
   input wire logic hold_in, // Rise: pin data low as a fault
   input wire logic [3:0] hold_falls_in, // Falls before release, 0 = never
   input wire logic [7:0] rd_byte_in, // Byte returned on every read
   output logic sda_oe_out // High pulls the data wire low
);
   logic act = 1'b0;
   logic rdm = 1'b0;
   logic first = 1'b0;
   logic stuck = 1'b0;
   logic drv = 1'b0;
   logic [7:0] sh = 8'h00;
   int cnt = 0;
   int nf = 0;
   assign sda_oe_out = stuck | drv;
   always @(posedge hold_in) begin
      nf = 0;
      stuck = 1'b1;
   end
   always @(negedge hold_in) stuck = 1'b0;
   // Lets go after the counted falls, as if the master had refused
   always @(negedge scl_in) begin
      if (stuck) begin
         nf++;
         if (nf == int'(hold_falls_in)) stuck = 1'b0;
      end
   end
   always @(negedge sda_in) begin
      if (scl_in === 1'b1 && !stuck) begin
         act = 1'b1;
         first = 1'b1;
         rdm = 1'b0;
         drv = 1'b0;
         // Fall right after start opens bit one
         cnt = -1;
      end
   end
   always @(posedge sda_in) begin
      if (scl_in === 1'b1) begin
         act = 1'b0;
         drv = 1'b0;
      end
   end
   always @(posedge scl_in) begin
      if (act && cnt < 8) sh = {sh[6:0], sda_in};
      else if (act && rdm && !first && sda_in) act = 1'b0;
   end
   always @(negedge scl_in) begin
      if (act) begin
         cnt++;
         if (cnt == 8) begin
            if (first) rdm = sh[0];
            drv = first | ~rdm;
         end else begin
            // Only the fall after the ack clock closes the address byte
            if (cnt == 9) begin
               cnt = 0;
               first = 1'b0;
            end
            drv = rdm & ~rd_byte_in[7 - cnt];
         end
      end
   end
endmodule : imbr_eeprom_model
